// ==== inc/ssp_defs.svh ====
// constants for the synchronous serial shift port: offsets, fields, resets, timing
// assumes a byte-wide register port addressed by the printed data-space offsets
`ifndef SSP_DEFS_SVH
`define SSP_DEFS_SVH

// ************************************************************
// register offsets
// ************************************************************
`define SSP_ADDR_DATA 8'h00_E0
`define SSP_ADDR_RATE 8'h00_E1
`define SSP_ADDR_CTRL 8'h00_E2
`define SSP_ADDR_MISC 8'h00_DD

// ************************************************************
// reset values
// ************************************************************
`define SSP_RATE_RESET 8'h00_00
`define SSP_CTRL_RESET 8'h00_00

// ************************************************************
// field positions
// ************************************************************
`define SSP_CTRL_RUN 7
`define SSP_CTRL_IE 6
`define SSP_CTRL_PHA 5
`define SSP_CTRL_SRC 4
`define SSP_CTRL_SIN 3
`define SSP_CTRL_GATE 2
`define SSP_CTRL_FBYP 1
`define SSP_CTRL_POL 0
`define SSP_RATE_FLAG 7
`define SSP_MISC_OUT 0

// ************************************************************
// timing
// ************************************************************
`define SSP_CORE_DIV 13
`define SSP_FILT_CYCLES 2

`endif

// ==== inc/ssp_pkg.sv ====
// types for the synchronous serial shift port
// assumes ssp_defs.svh holds the numeric constants
package ssp_pkg;

    typedef struct packed {
        logic run;
        logic irq_enable;
        logic clock_phase_sel;
        logic clock_source_sel;
        logic serial_in_enable;
        logic gated_start_sel;
        logic filter_bypass;
        logic clock_polarity_sel;
    } ssp_ctrl_t;

    typedef struct packed {
        logic irq_flag;
        logic [3:0] frame_length;
        logic [2:0] bit_rate_sel;
    } ssp_rate_t;

    typedef enum logic [1:0] {
        SSP_IDLE = 2'b00,
        SSP_WAIT_GATE = 2'b01,
        SSP_SHIFT = 2'b10
    } ssp_state_t;

endpackage

// ==== design/ssp_port.sv ====
// synchronous serial shift port: register file, bit clock divider, shifter
// assumes a one-cycle register port and pins coming from outside the clock domain
`timescale 1ns/10ps
`include "ssp_defs.svh"

module ssp_port
    import ssp_pkg::*;
#(
    parameter int CORE_DIV = `SSP_CORE_DIV
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    input wire logic serial_in,
    output logic serial_out,
    output logic serial_out_sel,
    input wire logic sclk_in,
    output logic sclk_out,
    output logic sclk_oe,
    output logic irq
);

    // ************************************************************
    // register port
    // ************************************************************
    ssp_ctrl_t ctrl;
    ssp_rate_t rate;
    logic misc_out_sel;
    logic [7:0] shifter;
    ssp_state_t state;

    wire sel_data = reg_addr == `SSP_ADDR_DATA;
    wire sel_rate = reg_addr == `SSP_ADDR_RATE;
    wire sel_ctrl = reg_addr == `SSP_ADDR_CTRL;
    wire sel_misc = reg_addr == `SSP_ADDR_MISC;
    wire busy = state != SSP_IDLE;
    wire wr_ctrl = reg_write && sel_ctrl;
    // no data write while running: the write is dropped
    wire wr_data = reg_write && sel_data && !ctrl.run;
    wire wr_rate = reg_write && sel_rate && !ctrl.run;
    // misc register is write only, reads as zero
    wire [7:0] next_rdata = sel_data ? shifter :
                            sel_rate ? rate :
                            sel_ctrl ? ctrl : 8'h00_00;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            reg_rdata <= 8'h00_00;
        end else begin
            reg_rdata <= reg_read ? next_rdata : 8'h00_00;
        end
    end

    // ************************************************************
    // input synchronisers and noise filters
    // ************************************************************
    logic [1:0] sin_sync, sck_sync;
    logic [1:0] sin_hist, sck_hist;
    logic sin_filt, sck_filt;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sin_sync <= 2'b00;
            sck_sync <= 2'b00;
            sin_hist <= 2'b00;
            sck_hist <= 2'b00;
            sin_filt <= 1'b0;
            sck_filt <= 1'b0;
        end else begin
            sin_sync <= {sin_sync[0], serial_in};
            sck_sync <= {sck_sync[0], sclk_in};
            sin_hist <= {sin_hist[0], sin_sync[1]};
            sck_hist <= {sck_hist[0], sck_sync[1]};
            // level must hold two cycles to pass
            if (sin_hist == 2'b11 || sin_hist == 2'b00) begin
                sin_filt <= sin_hist[1];
            end
            if (sck_hist == 2'b11 || sck_hist == 2'b00) begin
                sck_filt <= sck_hist[1];
            end
        end
    end

    // bypass takes the synchronised level straight
    wire sin_lvl = ctrl.filter_bypass ? sin_sync[1] : sin_filt;
    wire sck_lvl = ctrl.filter_bypass ? sck_sync[1] : sck_filt;

    // ************************************************************
    // core cycle clock and bit rate divider
    // ************************************************************
    function automatic logic [8:0] half_period(input logic [2:0] code);
        half_period = (code == 3'd7) ? 9'd256 : 9'(9'd1 << code);
    endfunction

    logic [4:0] core_cnt;
    logic [8:0] rate_cnt;
    logic sck_int;
    wire core_tick = core_cnt == 5'(CORE_DIV - 1);

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            core_cnt <= 5'd0;
        end else begin
            core_cnt <= core_tick ? 5'd0 : core_cnt + 5'd1;
        end
    end

    // master clock only runs during a shift
    wire master = ctrl.clock_source_sel;
    wire rate_tick = core_tick && rate_cnt == half_period(rate.bit_rate_sel) - 9'd1;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            rate_cnt <= 9'd0;
            sck_int <= 1'b0;
        end else if (state != SSP_SHIFT || !master) begin
            rate_cnt <= 9'd0;
            sck_int <= 1'b0;
        end else if (core_tick) begin
            rate_cnt <= rate_tick ? 9'd0 : rate_cnt + 9'd1;
            if (rate_tick) begin
                sck_int <= !sck_int;
            end
        end
    end

    // ************************************************************
    // edge detection
    // ************************************************************
    // polarity flips the pin level for a slave, the pin driver for a master
    wire sck_src = master ? sck_int : sck_lvl ^ ctrl.clock_polarity_sel;
    logic sck_prev;
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            sck_prev <= 1'b0;
        end else begin
            sck_prev <= sck_src;
        end
    end
    wire lead_edge = sck_src && !sck_prev && state == SSP_SHIFT;
    wire trail_edge = !sck_src && sck_prev && state == SSP_SHIFT;
    // phase 0 captures on leading edge, phase 1 on trailing
    wire cap_edge = ctrl.clock_phase_sel ? trail_edge : lead_edge;
    wire chg_edge = ctrl.clock_phase_sel ? lead_edge : trail_edge;

    // ************************************************************
    // shift engine
    // ************************************************************
    logic [3:0] bit_cnt;
    logic out_bit;
    logic out_valid;
    logic captured;

    wire in_bit = ctrl.serial_in_enable ? sin_lvl : 1'b0;
    wire last_cap = cap_edge && bit_cnt == rate.frame_length - 4'd1;
    wire sw_run_set = wr_ctrl && reg_wdata[`SSP_CTRL_RUN];
    // software clearing run while busy aborts
    wire sw_abort = wr_ctrl && !reg_wdata[`SSP_CTRL_RUN] && ctrl.run;
    wire frame_done = state == SSP_SHIFT && last_cap;
    wire gate_ok = !ctrl.gated_start_sel || sin_lvl;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state <= SSP_IDLE;
            bit_cnt <= 4'd0;
            captured <= 1'b0;
        end else if (sw_abort) begin
            state <= SSP_IDLE;
        end else begin
            unique case (state)
                SSP_IDLE: begin
                    if (sw_run_set || ctrl.run) begin
                        state <= SSP_WAIT_GATE;
                    end
                    bit_cnt <= 4'd0;
                    captured <= 1'b0;
                end
                SSP_WAIT_GATE: begin
                    // gated start waits for high input, then ignores it
                    if (!ctrl.run) begin
                        state <= SSP_IDLE;
                    end else if (gate_ok) begin
                        state <= SSP_SHIFT;
                    end
                end
                SSP_SHIFT: begin
                    if (frame_done) begin
                        state <= SSP_IDLE;
                    end
                    if (cap_edge) begin
                        bit_cnt <= bit_cnt + 4'd1;
                        captured <= 1'b1;
                    end
                end
                default: state <= SSP_IDLE;
            endcase
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            shifter <= 8'h00_00;
            out_bit <= 1'b0;
            out_valid <= 1'b0;
        end else if (wr_data) begin
            shifter <= reg_wdata;
            // phase 0 shows the top bit as soon as loaded
            out_bit <= reg_wdata[7];
            out_valid <= !ctrl.clock_phase_sel;
        end else begin
            if (cap_edge) begin
                // msb first, older bits fall off the top
                shifter <= {shifter[6:0], in_bit};
            end
            if (chg_edge) begin
                // phase 1 presents top bit on first change edge
                out_bit <= captured ? shifter[7] : shifter[7];
                out_valid <= 1'b1;
            end
            if (state == SSP_IDLE && !ctrl.clock_phase_sel) begin
                out_bit <= shifter[7];
                out_valid <= 1'b1;
            end
        end
    end

    // ************************************************************
    // control and rate registers
    // ************************************************************
    wire end_event = frame_done || (sw_abort && busy);
    // flag set at frame end when enabled, set beats clear
    wire flag_set = end_event && ctrl.irq_enable;
    wire flag_clr = wr_rate && !reg_wdata[`SSP_RATE_FLAG];

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ctrl <= `SSP_CTRL_RESET;
            rate <= `SSP_RATE_RESET;
            misc_out_sel <= 1'b0;
        end else begin
            if (wr_ctrl) begin
                ctrl <= reg_wdata;
            end
            // run self-clears when the frame completes
            if (frame_done && !wr_ctrl) begin
                ctrl.run <= 1'b0;
            end
            if (wr_rate) begin
                rate.frame_length <= reg_wdata[6:3];
                rate.bit_rate_sel <= reg_wdata[2:0];
            end
            if (flag_set) begin
                rate.irq_flag <= 1'b1;
            end else if (flag_clr) begin
                rate.irq_flag <= 1'b0;
            end
            if (reg_write && sel_misc) begin
                misc_out_sel <= reg_wdata[`SSP_MISC_OUT];
            end
        end
    end

    // ************************************************************
    // pins and request
    // ************************************************************
    // output routed only while misc bit set
    assign serial_out_sel = misc_out_sel;
    assign serial_out = misc_out_sel && out_valid ? out_bit : 1'b0;
    // master drives clock push-pull, polarity inverts idle level
    assign sclk_oe = master;
    assign sclk_out = sck_int ^ ctrl.clock_polarity_sel;
    // request is the flag gated by enable
    assign irq = rate.irq_flag && ctrl.irq_enable;

endmodule

// ==== verif/ssp_port_assertions.sv ====
// checker for the serial shift port, port-level relations only
// assumes it is bound onto ssp_port and shares its single clock domain
`timescale 1ns/10ps
`include "ssp_defs.svh"
module ssp_port_checker #(
    parameter int CORE_DIV = 13
) (
    input wire logic clock,
    input wire logic rst,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [7:0] reg_rdata,
    input wire logic serial_in,
    input wire logic serial_out,
    input wire logic serial_out_sel,
    input wire logic sclk_in,
    input wire logic sclk_out,
    input wire logic sclk_oe,
    input wire logic irq
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (rst);
    wire wr_ctrl = reg_write && reg_addr == `SSP_ADDR_CTRL;
    wire rd_ctrl = reg_read && reg_addr == `SSP_ADDR_CTRL;
    wire rd_rate = reg_read && reg_addr == `SSP_ADDR_RATE;
    // ************************************************************
    // assertions
    // ************************************************************
    a_out_gated: assert property (!serial_out_sel |-> !serial_out)
        else $error("serial out active while not routed");
    a_misc_route: assert property (reg_write && reg_addr == `SSP_ADDR_MISC
        |=> serial_out_sel == $past(reg_wdata[`SSP_MISC_OUT])) else $error("misc bit lost");
    a_misc_unread: assert property (reg_read && reg_addr == `SSP_ADDR_MISC
        |=> reg_rdata == 8'h00_00) else $error("misc register readable");
    a_master_drive: assert property (wr_ctrl |=> sclk_oe == $past(reg_wdata[4]))
        else $error("clock drive does not follow source bit");
    a_irq_flag: assert property (rd_rate && irq |=> reg_rdata[7])
        else $error("request without flag");
    a_irq_enable: assert property (rd_ctrl && irq |=> reg_rdata[6])
        else $error("request without enable");
    a_irq_mask: assert property (wr_ctrl && !reg_wdata[6] |=> !irq)
        else $error("masked request still high");
    a_ctrl_readback: assert property (wr_ctrl && !reg_wdata[7] ##2 rd_ctrl
        |=> reg_rdata == $past(reg_wdata, 3)) else $error("control readback wrong");
    a_reset_quiet: assert property ($fell(rst) |-> !irq && !sclk_oe && !serial_out_sel)
        else $error("outputs active after reset");
    c_start: cover property (wr_ctrl && reg_wdata[7]);
    c_request: cover property (irq);
    c_flag_read: cover property (rd_rate ##1 reg_rdata[7]);
endmodule

// ==== verif/ssp_peer.sv ====
// far-side peripheral: exchanges one word with the port on the clock routed to it
// assumes the bench tells it the polarity and phase before each frame
`timescale 1ns/10ps
module ssp_peer (
    input wire logic sclk,
    input wire logic mosi,
    input wire logic pol,
    input wire logic pha,
    input wire logic load,
    input wire logic [15:0] load_word,
    output logic miso,
    output logic [15:0] rx,
    output logic [15:0] edge_count
);
    logic [15:0] tx = 16'h0000;
    logic started = 1'b0;
    wire lead = sclk ^ pol;
    // ************************************************************
    // shifting
    // ************************************************************
    // clock taken, data driven
    assign miso = tx[15];
    initial begin
        rx = 16'h0000;
        edge_count = 16'h0000;
    end
    always @(posedge load) begin
        tx = load_word;
        rx = 16'h0000;
        edge_count = 16'h0000;
        started = 1'b0;
    end
    task take;
        rx = {rx[14:0], mosi};
        edge_count = edge_count + 16'h0001;
        started = 1'b1;
    endtask
    // no shift before the first capture, so phase 1 keeps the top bit
    task shift_out;
        if (started) tx = tx << 1;
    endtask
    always @(posedge lead) begin
        if (pha) shift_out();
        else take();
    end
    always @(negedge lead) begin
        if (pha) take();
        else shift_out();
    end
endmodule

// ==== verif/ssp_port_tb.sv ====
// self-checking bench for the serial shift port, register tasks plus a peer
// assumes ssp_peer follows whichever clock runs; the bench makes the pin clock for slave
`timescale 1ns/10ps
`include "ssp_defs.svh"
module ssp_port_tb;
    localparam int CORE_DIV = 13;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic pol = 1'b0;
    logic pha = 1'b0;
    logic load = 1'b0;
    logic prev_sclk = 1'b0;
    logic sclk_pin = 1'b0;
    logic [7:0] reg_addr = 8'h00_00;
    logic [7:0] reg_wdata = 8'h00_00;
    logic [7:0] d;
    logic [15:0] word = 16'h0000;
    logic [15:0] rx;
    logic [15:0] edge_count;
    wire [7:0] reg_rdata;
    wire serial_in, serial_out, serial_out_sel, sclk_out, sclk_oe, irq;
    int errors = 0;
    int total_checks = 0;
    int n;
    always #50 clock = ~clock;
    always @(posedge clock) prev_sclk <= sclk_out;
    ssp_port #(.CORE_DIV(CORE_DIV)) dut (.clock(clock), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .serial_in(serial_in), .serial_out(serial_out),
        .serial_out_sel(serial_out_sel), .sclk_in(sclk_pin), .sclk_out(sclk_out),
        .sclk_oe(sclk_oe), .irq(irq));
    ssp_peer peer (.sclk(sclk_oe ? sclk_out : sclk_pin), .mosi(serial_out), .pol(pol),
        .pha(pha), .load(load), .load_word(word), .miso(serial_in), .rx(rx),
        .edge_count(edge_count));
    // ************************************************************
    // tasks
    // ************************************************************
    task wrap_up;
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask
    task chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        total_checks++;
        if (got !== exp) begin
            errors++;
            $display("unexpected %s expected %h seen %h", what, exp, got);
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= v;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask
    task rd(input logic [7:0] a);
        @(posedge clock);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        @(negedge clock);
        d = reg_rdata;
    endtask
    // configure idle first so the peer never sees a polarity glitch
    task start(input logic [7:0] c, input logic [7:0] r, input logic [7:0] v,
        input logic [15:0] w);
        // data and rate loaded only while idle
        wr(`SSP_ADDR_DATA, v);
        wr(`SSP_ADDR_RATE, r);
        wr(`SSP_ADDR_CTRL, c);
        pol <= c[0];
        pha <= c[5];
        word <= w;
        @(posedge clock);
        load <= 1'b1;
        @(posedge clock);
        load <= 1'b0;
        wr(`SSP_ADDR_CTRL, c | 8'h80);
    endtask
    task finish_wait;
        d = 8'h80;
        for (n = 0; d[7]; n++) begin
            rd(`SSP_ADDR_CTRL);
            if (n > 20000) begin
                chk("run flag", 16'h0000, 16'(d));
                wrap_up();
            end
        end
    endtask
    task rise;
        for (n = 1; n < 9000; n++) begin
            @(posedge clock);
            if (sclk_out && !prev_sclk) break;
        end
        if (n >= 9000) begin
            chk("clock edge", 16'h0001, 16'h0000);
            wrap_up();
        end
    endtask
    // slave clock made by the bench, slow enough for the input filters
    task pulses(input int k);
        for (int j = 0; j < 2 * k; j++) begin
            repeat (20) @(posedge clock);
            sclk_pin <= ~sclk_pin;
        end
    endtask
    // ************************************************************
    // sequence
    // ************************************************************
    initial begin
        repeat (8) @(posedge clock);
        rst <= 1'b0;
        rd(`SSP_ADDR_RATE);
        chk("rate reset", 16'h0000, 16'(d));
        rd(`SSP_ADDR_CTRL);
        chk("control reset", 16'h0000, 16'(d));
        rd(`SSP_ADDR_MISC);
        chk("misc read", 16'h0000, 16'(d));
        rd(8'h50);
        chk("unmapped read", 16'h0000, 16'(d));
        wr(`SSP_ADDR_MISC, 8'h01);
        for (int i = 0; i < 4; i++) begin
            start(8'h58 | {2'b00, i[1], 4'b0000, i[0]}, 8'h40, 8'hA5, 16'h3C00);
            finish_wait();
            rd(`SSP_ADDR_DATA);
            chk("received byte", 16'h003C, 16'(d));
            chk("peer byte", 16'h00A5, rx);
            chk("bit count", 16'h0008, edge_count);
            rd(`SSP_ADDR_RATE);
            chk("end flag", 16'h00C0, 16'(d));
            chk("request", 16'h0001, 16'(irq));
            wr(`SSP_ADDR_RATE, 8'h40);
            @(negedge clock);
            chk("request cleared", 16'h0000, 16'(irq));
        end
        // filters bypassed on the long frame
        start(8'h1A, 8'h60, 8'h00, 16'hABC0);
        finish_wait();
        rd(`SSP_ADDR_DATA);
        chk("last eight", 16'h00BC, 16'(d));
        chk("long count", 16'h000C, edge_count);
        rd(`SSP_ADDR_RATE);
        chk("flag masked", 16'h0060, 16'(d));
        chk("no request", 16'h0000, 16'(irq));
        start(8'h50, 8'h40, 8'hFF, 16'hFF00);
        finish_wait();
        rd(`SSP_ADDR_DATA);
        chk("zero fill", 16'h0000, 16'(d));
        wr(`SSP_ADDR_RATE, 8'h40);
        // gated start waits for a high input, input shift off
        start(8'h14, 8'h08, 8'h00, 16'h0000);
        repeat (60) @(posedge clock);
        rd(`SSP_ADDR_CTRL);
        chk("gate hold", 16'h0094, 16'(d));
        chk("gate hold edges", 16'h0000, edge_count);
        @(posedge clock);
        word <= 16'h8000;
        @(posedge clock);
        load <= 1'b1;
        @(posedge clock);
        load <= 1'b0;
        finish_wait();
        chk("one bit frame", 16'h0001, edge_count);
        // slave with inverted polarity, bench makes the clock pin
        @(posedge clock);
        sclk_pin <= 1'b1;
        start(8'h49, 8'h40, 8'h96, 16'h6900);
        pulses(8);
        finish_wait();
        rd(`SSP_ADDR_DATA);
        chk("slave byte", 16'h0069, 16'(d));
        chk("slave peer byte", 16'h0096, rx);
        rd(`SSP_ADDR_RATE);
        chk("slave flag", 16'h00C0, 16'(d));
        wr(`SSP_ADDR_RATE, 8'h40);
        for (int c = 0; c < 8; c++) begin
            start(8'h10, {1'b0, 4'd2, c[2:0]}, 8'h00, 16'h0000);
            rise();
            rise();
            chk("bit period", 16'(2 * CORE_DIV * (c == 7 ? 256 : 1 << c)), 16'(n));
            chk("clock driven", 16'h0001, 16'(sclk_oe));
            finish_wait();
        end
        start(8'h50, 8'h47, 8'h00, 16'h0000);
        repeat (100) @(posedge clock);
        wr(`SSP_ADDR_CTRL, 8'h50);
        rd(`SSP_ADDR_CTRL);
        chk("abort control", 16'h0050, 16'(d));
        rd(`SSP_ADDR_RATE);
        chk("abort flag", 16'h00C7, 16'(d));
        chk("abort request", 16'h0001, 16'(irq));
        wr(`SSP_ADDR_CTRL, 8'h10);
        @(negedge clock);
        chk("masked request", 16'h0000, 16'(irq));
        wr(`SSP_ADDR_RATE, 8'h47);
        wr(`SSP_ADDR_DATA, 8'h80);
        @(negedge clock);
        chk("top bit", 16'h0001, 16'(serial_out));
        wr(`SSP_ADDR_MISC, 8'h00);
        @(negedge clock);
        chk("unrouted out", 16'h0000, 16'(serial_out));
        wrap_up();
    end
endmodule
bind ssp_port ssp_port_checker #(.CORE_DIV(CORE_DIV)) u_chk (.clock(clock), .rst(rst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
    .reg_rdata(reg_rdata), .serial_in(serial_in), .serial_out(serial_out),
    .serial_out_sel(serial_out_sel), .sclk_in(sclk_in), .sclk_out(sclk_out),
    .sclk_oe(sclk_oe), .irq(irq));
